/* File: inc/hsc_pkg.sv */
// constants shared by the hub strap and configuration-source selector
`default_nettype none

package hsc_pkg;

   // ------------------------------------------------------------
   // configuration source codes {upper, lower}
   // ------------------------------------------------------------
   localparam logic [1:0] SRC_DEFAULT = 2'h2;
   localparam logic [1:0] SRC_EEPROM  = 2'h3;
   localparam logic [6:0] SMB_ADDR    = 7'h2d;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_LOAD   = 12'h000;
   localparam logic [11:0] OFS_STRAP  = 12'h004;
   localparam logic [11:0] OFS_ACTIVE = 12'h008;

   // load register fields (written by the descriptor loader)
   localparam int LD_LED_EN   = 0;
   localparam int LD_P3_DIS   = 1;
   localparam int LD_FIXED    = 2;
   localparam int LD_GANG     = 4;
   localparam int LD_DONE     = 5;
   localparam int LD_NO_EEP   = 6;
   localparam logic [6:0] LOAD_RESET = 7'h00;

   // strap status register fields
   localparam int ST_SRC      = 0;
   localparam int ST_POL      = 2;
   localparam int ST_P3_DIS   = 3;
   localparam int ST_FIXED    = 4;
   localparam int ST_GANG     = 6;
   localparam int ST_OCS      = 7;
   localparam int ST_VALID    = 10;

   // active configuration register fields
   localparam int AC_LED_EN   = 0;
   localparam int AC_P3_DIS   = 1;
   localparam int AC_FIXED    = 2;
   localparam int AC_GANG     = 5;
   localparam int AC_READY    = 6;

endpackage : hsc_pkg

`default_nettype wire

/* File: design/hsc_strap_config.sv */
// strap sampling, configuration-source selection and pin polarity for the hub
`timescale 1ns/1ps
`default_nettype none

module hsc_strap_config (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // apb register port
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // strap pins (shared pins are given as their input side)
   input  wire logic [1:0]  fixedPortStrap,
   input  wire logic        port3DisableStrap,
   input  wire logic        gangPowerStrap,
   input  wire logic        powerOutPolarityStrap,
   input  wire logic        configSourceSelLo,
   input  wire logic        configSourceSelHi,
   // indicator pins, enable low while driven
   output logic [1:0]       port12IndicatorsOut,
   output logic [1:0]       port12IndicatorsOeN,
   output logic             port3IndicatorOut,
   output logic             port3IndicatorOeN,
   // downstream power pins
   output logic [2:0]       portPowerEnable,
   input  wire logic [2:0]  overcurrentSenseLow,
   // hub core side
   input  wire logic [2:0]  ledOn,
   input  wire logic [2:0]  portPowerReq,
   output logic [2:0]       overcurrent,
   output logic [2:0]       portFixed,
   output logic             port3Disabled,
   output logic             gangedPower,
   output logic             smbusSlaveEn,
   output logic [6:0]       smbusSlaveAddr,
   output logic             eepromLoadEn
);
   import hsc_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [6:0] strapMeta;
   logic [6:0] strapSync;
   logic [2:0] ocsMeta;
   logic [2:0] ocsSync;

   always_ff @(posedge core_clk) begin
      strapMeta <= {configSourceSelHi, configSourceSelLo, powerOutPolarityStrap,
                    gangPowerStrap, port3DisableStrap, fixedPortStrap};
      strapSync <= strapMeta;
   end

   // undriven sense inputs read high through the pad pull-ups
   always_ff @(posedge core_clk) begin
      ocsMeta <= overcurrentSenseLow;
      ocsSync <= ocsMeta;
   end

   // ------------------------------------------------------------
   // reset release detection and strap capture
   // ------------------------------------------------------------
   logic       rstHeld;
   logic       rstFilled;
   logic       captureNow;
   logic       strapsValid;
   logic [1:0] srcSel;
   logic       polarity;
   logic       strapP3Dis;
   logic [1:0] strapFixed;
   logic       strapGang;

   always_ff @(posedge core_clk) begin
      rstHeld <= sys_rst;
      rstFilled <= sys_rst & rstHeld;
   end

   assign captureNow = rstHeld & ~sys_rst;

   // pins are ignored after capture, so later board activity on the
   // shared led/strap pins cannot change the configuration
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         strapsValid <= 1'b0;
         srcSel      <= 2'h0;
         polarity    <= 1'b0;
         strapP3Dis  <= 1'b0;
         strapFixed  <= 2'h0;
         strapGang   <= 1'b0;
      end else if (captureNow) begin
         strapsValid <= 1'b1;
         srcSel      <= strapSync[6:5];
         polarity    <= strapSync[4];
         strapGang   <= strapSync[3];
         strapP3Dis  <= strapSync[2];
         strapFixed  <= strapSync[1:0];
      end
   end

   // ------------------------------------------------------------
   // apb register file
   // ------------------------------------------------------------
   logic [6:0]  loadReg;
   logic        apbAccess;
   logic        addrOk;
   logic [31:0] next_prdata;
   logic [2:0]  ocsActive;
   logic        ledEnEff;
   logic        p3DisEff;
   logic [2:0]  fixedEff;
   logic        gangEff;
   logic        cfgReady;

   assign apbAccess = psel & penable & ~pready;
   assign addrOk    = (paddr == OFS_LOAD) | (paddr == OFS_STRAP) | (paddr == OFS_ACTIVE);
   assign ocsActive = ~ocsSync;

   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         OFS_LOAD: begin
            next_prdata[6:0] = loadReg;
         end
         OFS_STRAP: begin
            next_prdata[ST_SRC+:2]   = srcSel;
            next_prdata[ST_POL]      = polarity;
            next_prdata[ST_P3_DIS]   = strapP3Dis;
            next_prdata[ST_FIXED+:2] = strapFixed;
            next_prdata[ST_GANG]     = strapGang;
            next_prdata[ST_OCS+:3]   = ocsActive;
            next_prdata[ST_VALID]    = strapsValid;
         end
         OFS_ACTIVE: begin
            next_prdata[AC_LED_EN]   = ledEnEff;
            next_prdata[AC_P3_DIS]   = p3DisEff;
            next_prdata[AC_FIXED+:3] = fixedEff;
            next_prdata[AC_GANG]     = gangEff;
            next_prdata[AC_READY]    = cfgReady;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // one wait state: the answer comes in the second access cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apbAccess;
         pslverr <= apbAccess & ~addrOk;
         prdata  <= (apbAccess & ~pwrite) ? next_prdata : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         loadReg <= LOAD_RESET;
      end else if (psel & penable & pready & pwrite & (paddr == OFS_LOAD)) begin
         loadReg <= pwdata[6:0];
      end
   end

   // ------------------------------------------------------------
   // effective configuration
   // ------------------------------------------------------------
   logic       modeDefault;
   logic       modeEeprom;
   logic       modeSmbus;
   logic       eepAbsent;
   logic [2:0] ledActiveLow;
   logic [2:0] ledDrive;

   assign modeDefault = (srcSel == SRC_DEFAULT);
   assign modeEeprom  = (srcSel == SRC_EEPROM);
   assign modeSmbus   = ~srcSel[1];
   assign eepAbsent   = modeEeprom & loadReg[LD_NO_EEP];

   always_comb begin
      ledEnEff     = 1'b0;
      p3DisEff     = 1'b0;
      fixedEff     = 3'h0;
      gangEff      = 1'b0;
      ledActiveLow = 3'h0;
      ledDrive     = 3'h0;
      cfgReady     = 1'b0;
      if (modeDefault) begin
         cfgReady = 1'b1;
         ledEnEff = 1'b1;
         ledDrive = 3'h7;
         p3DisEff = strapP3Dis;
         ledActiveLow[2] = strapP3Dis;
         gangEff  = strapGang;
         case (strapFixed)
            2'h0: begin
               fixedEff        = 3'h0;
               ledActiveLow[1:0] = 2'h0;
            end
            2'h1: begin
               fixedEff        = 3'h1;
               ledActiveLow[1:0] = 2'h1;
            end
            2'h2: begin
               fixedEff        = 3'h3;
               ledActiveLow[1:0] = 2'h2;
            end
            default: begin
               fixedEff        = 3'h7;
               ledActiveLow[1:0] = 2'h3;
            end
         endcase
      end else if (eepAbsent) begin
         cfgReady = 1'b1;
      end else begin
         // straps play no part here; the loader's fields are used
         cfgReady     = loadReg[LD_DONE];
         ledEnEff     = loadReg[LD_LED_EN];
         ledDrive     = {3{loadReg[LD_LED_EN]}};
         ledActiveLow = 3'h7;
         p3DisEff     = loadReg[LD_P3_DIS];
         gangEff      = loadReg[LD_GANG];
         case (loadReg[LD_FIXED+:2])
            2'h0:    fixedEff = 3'h0;
            2'h1:    fixedEff = 3'h1;
            2'h2:    fixedEff = 3'h3;
            default: fixedEff = 3'h7;
         endcase
      end
   end

   // ------------------------------------------------------------
   // power and overcurrent
   // ------------------------------------------------------------
   logic [2:0] powerOn;
   logic [2:0] next_overcurrent;

   always_comb begin
      powerOn = gangEff ? {3{portPowerReq[0]}} : portPowerReq;
      if (p3DisEff) begin
         powerOn[2] = 1'b0;
      end
      if (~(strapsValid & cfgReady)) begin
         powerOn = 3'h0;
      end
   end

   assign next_overcurrent = gangEff ? {3{|ocsActive}} : ocsActive;

   // during reset the inactive level tracks the polarity pin each cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         portPowerEnable <= {3{~strapSync[4]}};
      end else if (captureNow) begin
         portPowerEnable <= {3{~strapSync[4]}};
      end else begin
         portPowerEnable <= polarity ? powerOn : ~powerOn;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         overcurrent <= 3'h0;
      end else begin
         overcurrent <= strapsValid ? next_overcurrent : 3'h0;
      end
   end

   // ------------------------------------------------------------
   // indicators and status outputs
   // ------------------------------------------------------------
   logic [2:0] ledLevel;
   logic [2:0] ledOeN;

   assign ledLevel = ledOn ^ ledActiveLow;
   assign ledOeN   = ~(ledDrive & {3{strapsValid}});

   // pins stay released until capture so the straps can be read
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         port12IndicatorsOut <= 2'h0;
         port12IndicatorsOeN <= 2'h3;
         port3IndicatorOut   <= 1'b0;
         port3IndicatorOeN   <= 1'b1;
      end else begin
         port12IndicatorsOut <= ledLevel[1:0];
         port12IndicatorsOeN <= ledOeN[1:0];
         port3IndicatorOut   <= ledLevel[2];
         port3IndicatorOeN   <= ledOeN[2];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         portFixed      <= 3'h0;
         port3Disabled  <= 1'b0;
         gangedPower    <= 1'b0;
         smbusSlaveEn   <= 1'b0;
         smbusSlaveAddr <= 7'h00;
         eepromLoadEn   <= 1'b0;
      end else begin
         portFixed      <= fixedEff;
         port3Disabled  <= p3DisEff;
         gangedPower    <= gangEff;
         smbusSlaveEn   <= strapsValid & modeSmbus;
         smbusSlaveAddr <= (strapsValid & modeSmbus) ? SMB_ADDR : 7'h00;
         eepromLoadEn   <= strapsValid & modeEeprom & ~loadReg[LD_DONE];
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_strap_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
      captureNow |=> (srcSel == $past(strapSync[6:5])) && (polarity == $past(strapSync[4])))
      else $error("straps not captured at reset release");

   a_straps_held: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && !captureNow) |=> $stable(srcSel) && $stable(polarity) && $stable(strapFixed)
         && $stable(strapGang) && $stable(strapP3Dis))
      else $error("sampled strap changed after capture");

   a_power_reset: assert property (@(posedge core_clk)
      (sys_rst && rstFilled) |=> portPowerEnable == {3{~$past(strapSync[4])}})
      else $error("power output active during reset");

   a_power_polarity: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && !captureNow) |=> portPowerEnable == ($past(polarity) ? $past(powerOn) : ~$past(powerOn)))
      else $error("power output polarity wrong");

   a_smbus_address: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && !srcSel[1]) |=> smbusSlaveEn && (smbusSlaveAddr == 7'h2d))
      else $error("smbus slave not enabled at its address");

   a_fixed_decode: assert property (@(posedge core_clk) disable iff (sys_rst)
      (modeDefault && strapFixed == 2'h2) |-> (fixedEff == 3'h3) && (ledActiveLow[1:0] == 2'h2))
      else $error("fixed port code decoded wrong");

   a_eeprom_absent: assert property (@(posedge core_clk) disable iff (sys_rst)
      eepAbsent |-> !ledEnEff && !p3DisEff && (fixedEff == 3'h0) && !gangEff && cfgReady)
      else $error("missing eeprom did not zero the configuration");

   a_port3_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && p3DisEff && !captureNow) |=> portPowerEnable[2] == ~polarity)
      else $error("disabled port three powered");

   a_led_loaded: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && !modeDefault && ledEnEff) |=> !port3IndicatorOeN && (port3IndicatorOut == ~$past(ledOn[2])))
      else $error("loaded indicator not active low");

   a_gang_sense: assert property (@(posedge core_clk) disable iff (sys_rst)
      (strapsValid && gangEff) |=> (overcurrent == 3'h0) || (overcurrent == 3'h7))
      else $error("ganged overcurrent not shared");

   a_straps_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!modeDefault && !eepAbsent) |-> (gangEff == loadReg[LD_GANG]) && (p3DisEff == loadReg[LD_P3_DIS]))
      else $error("strap used outside default mode");

endmodule : hsc_strap_config

`default_nettype wire

/* File: verification/hsc_board_model.sv */
// board strapping and current monitor model driving the hub strap pins
`timescale 1ns/1ps
`default_nettype none

module hsc_board_model (
   // settings chosen by the bench
   input  wire logic [1:0] setSource,
   input  wire logic [1:0] setFixed,
   input  wire logic       setP3,
   input  wire logic       setGang,
   input  wire logic       setPol,
   input  wire logic [2:0] senseDrive,
   // strap pins
   output logic [1:0]      fixedPortStrap,
   output logic            port3DisableStrap,
   output logic            gangPowerStrap,
   output logic            powerOutPolarityStrap,
   output logic            configSourceSelLo,
   output logic            configSourceSelHi,
   // current monitor pins
   output logic [2:0]      overcurrentSenseLow
);
   // ------------------------------------------------------------
   // strap resistors
   // ------------------------------------------------------------
   assign fixedPortStrap        = setFixed;
   assign port3DisableStrap     = setP3;
   assign gangPowerStrap        = setGang;
   assign powerOutPolarityStrap = setPol;
   assign configSourceSelLo     = setSource[0];
   assign configSourceSelHi     = setSource[1];
   // ------------------------------------------------------------
   // monitor pulls a line low on overcurrent, else the pull-up wins
   // ------------------------------------------------------------
   assign overcurrentSenseLow   = ~senseDrive;
endmodule : hsc_board_model

`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the hub strap and configuration-source selector
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin \
   numChecks++; \
   if ((got) !== (ex)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
   end \
end

module tb_top;
   import hsc_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdDummy;
   logic        pready, pslverr, erDummy;
   logic [1:0]  setSource = 2'h2, setFixed = 2'h0;
   logic        setP3 = 1'b0, setGang = 1'b0, setPol = 1'b0;
   logic [2:0]  senseDrive = 3'h0;
   logic [1:0]  fixedPortStrap, port12IndicatorsOut, port12IndicatorsOeN;
   logic        port3DisableStrap, gangPowerStrap, powerOutPolarityStrap;
   logic        configSourceSelLo, configSourceSelHi, port3IndicatorOut, port3IndicatorOeN;
   logic [2:0]  portPowerEnable, overcurrentSenseLow, overcurrent, portFixed;
   logic [2:0]  ledOn = 3'h3, portPowerReq = 3'h5;
   logic        port3Disabled, gangedPower, smbusSlaveEn, eepromLoadEn;
   logic [6:0]  smbusSlaveAddr;
   int          errors = 0, numChecks = 0, cycles = 0;

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   hsc_board_model i_hsc_board_model (.setSource(setSource), .setFixed(setFixed), .setP3(setP3),
      .setGang(setGang), .setPol(setPol), .senseDrive(senseDrive), .fixedPortStrap(fixedPortStrap),
      .port3DisableStrap(port3DisableStrap), .gangPowerStrap(gangPowerStrap),
      .powerOutPolarityStrap(powerOutPolarityStrap), .configSourceSelLo(configSourceSelLo),
      .configSourceSelHi(configSourceSelHi), .overcurrentSenseLow(overcurrentSenseLow));

   hsc_strap_config i_hsc_strap_config (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fixedPortStrap(fixedPortStrap),
      .port3DisableStrap(port3DisableStrap), .gangPowerStrap(gangPowerStrap),
      .powerOutPolarityStrap(powerOutPolarityStrap), .configSourceSelLo(configSourceSelLo),
      .configSourceSelHi(configSourceSelHi), .port12IndicatorsOut(port12IndicatorsOut),
      .port12IndicatorsOeN(port12IndicatorsOeN), .port3IndicatorOut(port3IndicatorOut),
      .port3IndicatorOeN(port3IndicatorOeN), .portPowerEnable(portPowerEnable),
      .overcurrentSenseLow(overcurrentSenseLow), .ledOn(ledOn), .portPowerReq(portPowerReq),
      .overcurrent(overcurrent), .portFixed(portFixed), .port3Disabled(port3Disabled),
      .gangedPower(gangedPower), .smbusSlaveEn(smbusSlaveEn), .smbusSlaveAddr(smbusSlaveAddr),
      .eepromLoadEn(eepromLoadEn));

   // ------------------------------------------------------------
   // bus and reset tasks, entered just after a rising edge
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps a following setup off the release edge
      @(posedge core_clk);
   endtask : apb

   task automatic chkReg(input logic [11:0] a, input logic [32:0] ex);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0, rd, er);
      `CHK("register read", ex, {er, rd})
   endtask : chkReg

   task automatic doReset(input logic [1:0] src, input logic [1:0] fx, input logic p3, gang, pol);
      setSource <= src;
      setFixed <= fx;
      setP3 <= p3;
      setGang <= gang;
      setPol <= pol;
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1 `CHK("power in reset", {3{~pol}}, portPowerEnable)
      repeat (3) @(posedge core_clk);
   endtask : doReset

   task automatic chkDefault(input logic [1:0] fx, input logic p3, gang, pol, input logic [2:0] oc);
      logic [2:0] on;
      on = (gang ? {3{portPowerReq[0]}} : portPowerReq) & {~p3, 2'b11};
      #1 `CHK("fixed mask", {fx == 2'b11, fx[1], |fx}, portFixed)
      `CHK("port3 off", p3, port3Disabled)
      `CHK("ganged", gang, gangedPower)
      `CHK("source", 9'h000, {smbusSlaveEn, eepromLoadEn, smbusSlaveAddr})
      `CHK("leds", {3'b000, ledOn ^ {p3, fx}}, {port3IndicatorOeN, port12IndicatorsOeN,
         port3IndicatorOut, port12IndicatorsOut})
      `CHK("power", pol ? on : ~on, portPowerEnable)
      `CHK("overcurrent", gang ? {3{|oc}} : oc, overcurrent)
      @(posedge core_clk);
      chkReg(OFS_STRAP, {22'h0, 1'b1, oc, gang, fx, p3, pol, 2'b10});
   endtask : chkDefault

   task automatic close_out;
      $display("checks %0d errors %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      doReset(2'b10, 2'b00, 1'b0, 1'b0, 1'b0);
      chkReg(OFS_LOAD, 33'h0);
      chkReg(12'h00c, {1'b1, 32'h0});
      for (int k = 0; k < 4; k++) begin
         doReset(2'b10, 2'(k), k[0], k[1], k[0] ^ k[1]);
         chkDefault(2'(k), k[0], k[1], k[0] ^ k[1], 3'b000);
         // pins move after release; captured values must not
         setFixed <= ~2'(k);
         setP3 <= ~k[0];
         setGang <= ~k[1];
         setPol <= ~(k[0] ^ k[1]);
         senseDrive <= 3'b010;
         repeat (5) @(posedge core_clk);
         chkDefault(2'(k), k[0], k[1], k[0] ^ k[1], 3'b010);
         senseDrive <= 3'b000;
      end
      for (int s = 0; s < 2; s++) begin
         doReset({1'b0, s[0]}, 2'b11, 1'b1, 1'b1, 1'b1);
         #1 `CHK("slave", {1'b1, 7'h2d, 1'b0}, {smbusSlaveEn, smbusSlaveAddr, eepromLoadEn})
         `CHK("straps unused", 5'h0, {portFixed, port3Disabled, gangedPower})
         `CHK("power held off", 3'b000, portPowerEnable)
         `CHK("leds undriven", 3'b111, {port3IndicatorOeN, port12IndicatorsOeN})
         @(posedge core_clk);
         apb(1'b1, OFS_STRAP, 32'hffff_ffff, rdDummy, erDummy);
         chkReg(OFS_STRAP, {22'h0, 11'h47c | 11'(s)});
         apb(1'b1, OFS_LOAD, 32'h25, rdDummy, erDummy);
         chkReg(OFS_LOAD, 33'h25);
         chkReg(OFS_ACTIVE, 33'h45);
         #1 `CHK("leds low", {3'b000, ~ledOn}, {port3IndicatorOeN, port12IndicatorsOeN,
            port3IndicatorOut, port12IndicatorsOut})
         `CHK("fixed loaded", 3'b001, portFixed)
         `CHK("power loaded", portPowerReq, portPowerEnable)
         @(posedge core_clk);
      end
      doReset(2'b11, 2'b11, 1'b1, 1'b1, 1'b0);
      #1 `CHK("eeprom mode", 2'b10, {eepromLoadEn, smbusSlaveEn})
      @(posedge core_clk);
      apb(1'b1, OFS_LOAD, 32'h7f, rdDummy, erDummy);
      chkReg(OFS_ACTIVE, 33'h40);
      #1 `CHK("all zero", 9'h007, {eepromLoadEn, portFixed, port3Disabled, gangedPower,
         port3IndicatorOeN, port12IndicatorsOeN})
      // zeroed config leaves ports unganged; power follows the core's requests, active low
      `CHK("power zero config", ~portPowerReq, portPowerEnable)
      close_out();
   end
endmodule : tb_top

`default_nettype wire
